// ---- src/fpma_top.sv ----
// Purpose: Programming-mode access to the on-chip code flash and its security bits.
// Assumes: Pins are asynchronous to clk and are held stable while an operation runs.
// Notes:   Erase walks the whole array one byte per clock, reported on erase_busy.
`default_nettype none

module fpma_top
  import fpma_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              resetn,
  // Mode pins.
  input  wire logic              rst_pin,
  input  wire logic              ale,
  input  wire logic              program_store_strobe_n,
  input  wire logic              erase_select_ctrl,
  input  wire logic              upper_mode_ctrl_b,
  input  wire logic              upper_mode_ctrl_c,
  input  wire logic              drive_mode_ctrl,
  input  wire logic              chip_sel_n,
  input  wire logic              out_en_n,
  input  wire logic [1:0]        supply_level,
  // Address and data ports.
  input  wire logic [7:0]        port_two,
  input  wire logic [7:0]        port_one,
  input  wire logic [7:0]        port_zero_in,
  output var  logic [7:0]        port_zero_out,
  output var  logic              port_zero_oe,
  // Normal-mode table read gate.
  input  wire logic              tbl_exec_ext,
  output var  logic              tbl_internal_ok,
  // Status.
  output var  logic              erase_busy,
  output var  logic [7:0]        sec_bits
);

  // Complete register state of this module.
  typedef struct packed {
    fpma_pins_t  s1;      // First synchroniser stage.
    fpma_pins_t  s2;      // Second synchroniser stage.
    fpma_st_t    st;      // Write sequencer state.
    logic [15:0] cnt;     // Erase sweep address.
    logic [7:0]  sec;     // Security register.
    logic [7:0]  dout;    // Byte driven on port zero.
    logic        doe;     // Port zero drive enable.
    logic        tbl;     // Table read may reach internal code.
  } fpma_state_t;

  fpma_state_t       q;          // Registered state.
  fpma_state_t       n;          // Next state.
  fpma_pins_t        pin_raw;    // Raw pin bundle.
  fpma_pins_t        p;          // Synchronised pins.
  fpma_op_t          op;         // Decoded operation.
  logic [15:0]       addr;       // Programming address.
  logic              is_sec;     // Address selects the security register.
  logic              locked;     // Lock bit programmed.
  logic              enc_on;     // Encryption enabled.
  logic              erase_go;   // Erase accepted this cycle.
  logic              prog_we;    // Code byte program strobe.
  logic              mem_we;     // Array write enable.
  logic [15:0]       mem_waddr;  // Array write address.
  logic [7:0]        mem_wdata;  // Array write data.
  logic [7:0]        mem_rdata;  // Array read data.
  logic [7:0]        out_byte;   // Byte to present next.

  // Gather the pins so they cross into clk together.
  assign pin_raw = '{rst: rst_pin, ale: ale, program_store_strobe_n_n: program_store_strobe_n,
                     sel: erase_select_ctrl, mode_b: upper_mode_ctrl_b,
                     mode_c: upper_mode_ctrl_c, drv: drive_mode_ctrl,
                     ce_n: chip_sel_n, oe_n: out_en_n, supply: supply_level,
                     p2: port_two, p1: port_one, p0: port_zero_in};

  // Only the second stage is read by logic.
  assign p      = q.s2;
  assign addr   = {p.p2, p.p1};
  assign is_sec = (addr == SEC_ADDR);
  assign locked = !q.sec[SEC_LOCK_BIT];
  assign enc_on = !q.sec[SEC_ENC_BIT];

  // Decode the operation from pin levels; anything else is no operation.
  always_comb begin
    op = OP_NONE;
    if (p.rst && !p.ale && p.program_store_strobe_n_n && !p.mode_b && !p.mode_c && !p.drv) begin
      if (!p.sel && !p.ce_n && !p.oe_n && p.supply == SUP_HIGH) begin
        op = OP_READ;
      end else if (!p.sel && !p.ce_n && p.oe_n && p.supply == SUP_VCP) begin
        op = OP_PROG;
      end else if (!p.sel && p.ce_n && !p.oe_n && p.supply == SUP_VCP) begin
        op = OP_PVER;
      end else if (p.sel && !p.ce_n && p.oe_n && p.supply == SUP_VEP
                   && !p.p1[0] && p.p0 == ERASED_BYTE) begin
        op = OP_ERASE;
      end else if (p.sel && p.ce_n && !p.oe_n && p.supply == SUP_VEP) begin
        op = OP_EVER;
      end
    end
  end

  // A fresh erase is only accepted from idle.
  assign erase_go = (q.st == ST_IDLE) && (op == OP_ERASE);

  // Code bytes are written once per program entry, never while locked.
  assign prog_we = (q.st == ST_PROG) && (op == OP_PROG) && !is_sec && !locked;

  // The array write port is shared between program and the erase sweep.
  always_comb begin
    mem_we    = prog_we || (q.st == ST_ERASE);
    mem_waddr = addr;
    mem_wdata = mem_rdata & p.p0;
    if (q.st == ST_ERASE) begin
      mem_waddr = q.cnt;
      mem_wdata = ERASED_BYTE;
    end
  end

  // Choose the byte for port zero and apply the encoding when enabled.
  always_comb begin
    out_byte = is_sec ? q.sec : mem_rdata;
    if (enc_on) begin
      out_byte = out_byte ^ ENC_KEY ^ addr[7:0];
    end
    if (locked && !is_sec) begin
      out_byte = LOCK_FILL;
    end
  end

  // Fill the next state.
  always_comb begin
    n      = q;
    n.s1   = pin_raw;
    n.s2   = q.s1;
    // Drive only for read-type operations; output enable high gives none.
    n.doe  = (op == OP_READ || op == OP_PVER || op == OP_EVER)
             && (q.st != ST_ERASE);
    n.dout = out_byte;
    // External table reads reach internal code only when not inhibited.
    n.tbl  = !(tbl_exec_ext && !q.sec[SEC_INH_BIT]);
    unique case (q.st)
      ST_IDLE: begin
        // Inhibit decodes to no operation, so nothing starts here.
        if (op == OP_PROG) begin
          n.st = ST_PROG;
        end else if (op == OP_ERASE) begin
          n.st  = ST_ERASE;
          n.cnt = CNT_RESET;
          n.sec = SEC_RESET;
        end
      end
      ST_PROG: begin
        // Security bits can only be cleared by programming.
        if (op == OP_PROG && is_sec) begin
          n.sec = q.sec & p.p0;
        end
        n.st = ST_HOLD;
      end
      ST_ERASE: begin
        // Sweep every cell to the erased value.
        if (q.cnt == MEM_LAST) begin
          n.st = ST_HOLD;
        end else begin
          n.cnt = q.cnt + 16'h0001;
        end
      end
      ST_HOLD: begin
        // Wait for the pins to leave the write operation.
        if (op != OP_PROG && op != OP_ERASE) begin
          n.st = ST_IDLE;
        end
      end
    endcase
  end

  // Register the state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q     <= '0;
      q.sec <= SEC_RESET;
      q.tbl <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Code array.
  fpma_mem u_mem (
    .clk    (clk),
    .resetn (resetn),
    .we     (mem_we),
    .waddr  (mem_waddr),
    .wdata  (mem_wdata),
    .raddr  (addr),
    .rdata  (mem_rdata)
  );

  // Outputs come straight from the state register.
  assign port_zero_out   = q.dout;
  assign port_zero_oe    = q.doe;
  assign tbl_internal_ok = q.tbl;
  assign erase_busy      = (q.st == ST_ERASE);
  assign sec_bits        = q.sec;

  // Checks on the behaviour above.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Three cycles of a steady read.
  sequence s_read_held;
    (op == OP_READ) [*3];
  endsequence

  // A program entry from idle.
  sequence s_prog_entry;
    (q.st == ST_IDLE) && (op == OP_PROG);
  endsequence

  a_oe_high_float: assert property (p.oe_n |=> !port_zero_oe)
    else $error("port zero driven while output enable high");

  a_read_drives_port: assert property (s_read_held |-> port_zero_oe)
    else $error("read did not drive port zero");

  a_bad_pins_float: assert property ((op == OP_NONE) |=> !port_zero_oe)
    else $error("port zero driven without an operation");

  a_inhibit_no_write: assert property ((p.ce_n && p.oe_n && q.st == ST_IDLE) |=> (q.st == ST_IDLE))
    else $error("write started while inhibited");

  a_prog_one_write: assert property (s_prog_entry |=> (q.st == ST_PROG) ##1 (q.st == ST_HOLD))
    else $error("program sequence did not run once");

  a_prog_clears_only: assert property (prog_we |-> ((mem_wdata & ~mem_rdata) == 8'h00))
    else $error("program set a bit");

  a_sec_sticky_bits: assert property (!erase_go |=> ((q.sec & ~$past(q.sec)) == 8'h00))
    else $error("security bit restored without erase");

  a_erase_sets_sec: assert property (erase_go |=> (q.sec == SEC_RESET) && erase_busy)
    else $error("erase did not reset security bits");

  a_lock_denies_read: assert property ((op == OP_READ && locked && !is_sec) |=> (port_zero_out == LOCK_FILL))
    else $error("locked read returned data");

  a_table_read_gate: assert property ((tbl_exec_ext && !q.sec[SEC_INH_BIT]) |=> !tbl_internal_ok)
    else $error("inhibited table read reached internal code");

endmodule // fpma_top

`default_nettype wire

// ---- src/fpma_pkg.sv ----
// Purpose: Shared constants and types for the flash programming-mode access block.
// Assumes: Supply pin level arrives already classified into a two-bit level code.
// Notes:   All pin inputs are resynchronised inside the top module before use.
`default_nettype none

package fpma_pkg;

  // Data and address widths of the code store.
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 16;
  localparam int          MEM_DEPTH   = 65536;

  // Classified level of the supply/external-access pin.
  localparam logic [1:0]  SUP_LOW     = 2'h0;
  localparam logic [1:0]  SUP_HIGH    = 2'h1;
  localparam logic [1:0]  SUP_VCP     = 2'h2;
  localparam logic [1:0]  SUP_VEP     = 2'h3;

  // Address map and byte values.
  localparam logic [15:0] SEC_ADDR    = 16'hFFFF;
  localparam logic [15:0] MEM_LAST    = 16'hFFFF;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam logic [7:0]  SEC_RESET   = 8'hFF;
  localparam logic [7:0]  LOCK_FILL   = 8'hFF;
  localparam logic [7:0]  DOUT_RESET  = 8'h00;
  localparam logic [7:0]  ENC_KEY     = 8'hA5;

  // Bit positions inside the security register.
  localparam int          SEC_LOCK_BIT = 0;
  localparam int          SEC_INH_BIT  = 1;
  localparam int          SEC_ENC_BIT  = 2;

  // Decoded programming operation.
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_READ  = 3'h1,
    OP_PROG  = 3'h2,
    OP_PVER  = 3'h3,
    OP_ERASE = 3'h4,
    OP_EVER  = 3'h5
  } fpma_op_t;

  // Write sequencer states, Gray coded along idle-prog-hold and idle-erase-hold.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_HOLD  = 2'b11,
    ST_ERASE = 2'b10
  } fpma_st_t;

  // Bundle of all programming pins, sampled together.
  typedef struct packed {
    logic       rst;
    logic       ale;
    logic       program_store_strobe_n_n;
    logic       sel;
    logic       mode_b;
    logic       mode_c;
    logic       drv;
    logic       ce_n;
    logic       oe_n;
    logic [1:0] supply;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] p0;
  } fpma_pins_t;

endpackage : fpma_pkg

`default_nettype wire

// ---- src/fpma_mem.sv ----
// Purpose: Byte-wide code store with one write port and a registered read port.
// Assumes: Write and read may target the same word; read then returns old data.
// Notes:   The array itself has no reset, as a flash array would not.
`default_nettype none

module fpma_mem
  import fpma_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              resetn,
  // Write port.
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  // Read port.
  input  wire logic [ADDR_W-1:0] raddr,
  output var  logic [DATA_W-1:0] rdata
);

  // Storage cells.
  logic [DATA_W-1:0] cells [0:MEM_DEPTH-1];

  // Writes land on the rising edge.
  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  // Read data always comes out of a register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= DOUT_RESET;
    end else begin
      rdata <= cells[raddr];
    end
  end

endmodule // fpma_mem

`default_nettype wire

// ---- dv/fpma_prog_model.sv ----
// Purpose: Behavioural parallel programmer that drives the programming pins.
// Assumes: Tasks are called from the bench; levels change just after a rising edge.
// Notes:   The programmer drives the data port only while it holds output enable high.
`default_nettype none

module fpma_prog_model
  import fpma_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Pins toward the device.
  output var  logic        ale,
  output var  logic        rst_p,
  output var  logic        program_store_strobe_n_n,
  output var  logic        sel,
  output var  logic        ce_n,
  output var  logic        oe_n,
  output var  logic [1:0]  sup,
  output var  logic [15:0] addr,
  output var  logic [7:0]  dat
);
  timeunit 1ns;
  timeprecision 1ps;

  // Start parked in the inhibit combination with the strobe idle.
  initial begin
    ale    = 1'b0;
    rst_p  = 1'b1;
    program_store_strobe_n_n = 1'b1;
    sel  = 1'b0;
    ce_n = 1'b1;
    oe_n = 1'b1;
    sup  = SUP_HIGH;
    addr = 16'h0000;
    dat  = 8'hFF;
  end

  // Apply one operation's levels and hold them long enough to be decoded and answered.
  // The fault code breaks one mode pin: 1 strobe high, 2 reset pin low, 3 store strobe low.
  task automatic drive(input logic s, input logic c, input logic o, input logic [1:0] v,
                       input logic [15:0] a, input logic [7:0] d, input logic [1:0] fault);
    @(posedge clk);
    ale    <= (fault == 2'h1);
    rst_p  <= (fault != 2'h2);
    program_store_strobe_n_n <= (fault != 2'h3);
    sel  <= s;
    ce_n <= c;
    oe_n <= o;
    sup  <= v;
    addr <= a;
    dat  <= d;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Leave the operation by returning to the inhibit levels at logic supply.
  task automatic rel();
    @(posedge clk);
    ale    <= 1'b0;
    rst_p  <= 1'b1;
    program_store_strobe_n_n <= 1'b1;
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    sup  <= SUP_HIGH;
    repeat (4) @(posedge clk);
    #1;
  endtask
endmodule // fpma_prog_model

`default_nettype wire

// ---- dv/fpma_top_tb_top.sv ----
// Purpose: Self-checking bench for programming-mode access to the code flash.
// Assumes: One erase sweep of the whole array fits the run.
// Notes:   Security bits are exercised before the erase since the array has no reset.
`default_nettype none

module fpma_top_tb_top
  import fpma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;            // 50 MHz clock.
  logic        resetn;         // Bench reset.
  logic        tbl_exec_ext;   // Table read runs from external memory.
  logic        ale, sel, ce_n, oe_n, rst_p, program_store_strobe_n_n;
  logic [1:0]  sup;
  logic [15:0] addr;
  logic [7:0]  dat, p0_out, p0_wire, sec_bits;
  logic        p0_oe, tbl_ok, erase_busy;
  int          err_total;      // Mismatches seen.
  int          compares;       // Comparisons made.

  // Released data line shows the programmer's last byte while output enable is high, and its inverse while it is low.
  assign p0_wire = p0_oe ? p0_out : (oe_n ? dat : ~dat);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  fpma_prog_model prg (.clk(clk), .ale(ale), .rst_p(rst_p), .program_store_strobe_n_n(program_store_strobe_n_n), .sel(sel), .ce_n(ce_n),
                       .oe_n(oe_n), .sup(sup), .addr(addr), .dat(dat));

  fpma_top uut (.clk(clk), .resetn(resetn), .rst_pin(rst_p), .ale(ale),
                .program_store_strobe_n(program_store_strobe_n_n), .erase_select_ctrl(sel), .upper_mode_ctrl_b(1'b0),
                .upper_mode_ctrl_c(1'b0), .drive_mode_ctrl(1'b0), .chip_sel_n(ce_n), .out_en_n(oe_n),
                .supply_level(sup), .port_two(addr[15:8]), .port_one(addr[7:0]), .port_zero_in(p0_wire),
                .port_zero_out(p0_out), .port_zero_oe(p0_oe), .tbl_exec_ext(tbl_exec_ext),
                .tbl_internal_ok(tbl_ok), .erase_busy(erase_busy), .sec_bits(sec_bits));

  // Compare one byte and report a difference.
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Program one byte and leave the program levels.
  task automatic pg(input logic [15:0] a, input logic [7:0] d);
    prg.drive(1'b0, 1'b0, 1'b1, SUP_VCP, a, d, 2'h0);
    prg.rel();
  endtask

  // Read-type access: drive, data and release of the port are all checked.
  task automatic rd(input string n, input logic s, input logic c, input logic [1:0] v,
                    input logic [15:0] a, input logic [7:0] e);
    prg.drive(s, c, 1'b0, v, a, 8'h00, 2'h0);
    chk({n, " oe"}, {7'h00, p0_oe}, 8'h01);
    chk(n, p0_out, e);
    prg.rel();
    chk({n, " float"}, {7'h00, p0_oe}, 8'h00);
  endtask

  // Reset levels of every output except the port zero data byte.
  task automatic t_reset();
    chk("sec reset", sec_bits, SEC_RESET);
    chk("busy reset", {7'h00, erase_busy}, 8'h00);
    chk("gate reset", {7'h00, tbl_ok}, 8'h01);
    chk("oe reset", {7'h00, p0_oe}, 8'h00);
  endtask

  // Security bit cleared, then a later program of ones cannot restore it.
  task automatic t_sec_pre();
    pg(SEC_ADDR, 8'hFD);
    chk("sec prog", sec_bits, 8'hFD);
    pg(SEC_ADDR, 8'hFF);
    chk("sec sticky", sec_bits, 8'hFD);
  endtask

  // Whole-chip erase, then erase verify and a plain read.
  task automatic t_erase();
    int i;
    prg.drive(1'b1, 1'b0, 1'b1, SUP_VEP, 16'h0000, 8'hFF, 2'h0);
    chk("busy on", {7'h00, erase_busy}, 8'h01);
    // Sample the busy flag after each edge has settled, never in the edge's own time step.
    for (i = 0; i < 70000 && erase_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("erase done", {7'h00, erase_busy}, 8'h00);
    if (erase_busy !== 1'b0) begin
      final_report();
    end
    prg.rel();
    chk("sec erased", sec_bits, 8'hFF);
    rd("ever lo", 1'b1, 1'b1, SUP_VEP, 16'h1234, ERASED_BYTE);
    rd("ever hi", 1'b1, 1'b1, SUP_VEP, 16'hFFFE, ERASED_BYTE);
    rd("read erased", 1'b0, 1'b0, SUP_HIGH, 16'h0000, ERASED_BYTE);
  endtask

  // Program with verify after each byte; a second program only clears bits.
  task automatic t_prog();
    pg(16'h1234, 8'h5A);
    rd("pver 1", 1'b0, 1'b1, SUP_VCP, 16'h1234, 8'h5A);
    pg(16'h1234, 8'hF0);
    rd("pver 2", 1'b0, 1'b1, SUP_VCP, 16'h1234, 8'h50);
  endtask

  // Broken mode pins, inhibit at both voltages and output disable write nothing.
  task automatic t_faults();
    prg.drive(1'b0, 1'b0, 1'b1, SUP_VCP, 16'h1234, 8'h00, 2'h1);
    prg.rel();
    prg.drive(1'b0, 1'b0, 1'b1, SUP_VCP, 16'h1234, 8'h00, 2'h3);
    prg.rel();
    prg.drive(1'b0, 1'b0, 1'b0, SUP_HIGH, 16'h1234, 8'h00, 2'h2);
    chk("reset low oe", {7'h00, p0_oe}, 8'h00);
    prg.rel();
    prg.drive(1'b0, 1'b1, 1'b1, SUP_VCP, 16'h1234, 8'h00, 2'h0);
    prg.rel();
    prg.drive(1'b1, 1'b1, 1'b1, SUP_VEP, 16'h0000, 8'hFF, 2'h0);
    chk("inhibit busy", {7'h00, erase_busy}, 8'h00);
    prg.rel();
    prg.drive(1'b0, 1'b0, 1'b1, SUP_HIGH, 16'h1234, 8'h00, 2'h0);
    chk("disable oe", {7'h00, p0_oe}, 8'h00);
    prg.rel();
    rd("after faults", 1'b0, 1'b0, SUP_HIGH, 16'h1234, 8'h50);
  endtask

  // Table-read gate follows the inhibit bit.
  task automatic t_table();
    @(posedge clk);
    tbl_exec_ext <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("gate open", {7'h00, tbl_ok}, 8'h01);
    pg(SEC_ADDR, 8'hFD);
    chk("gate shut", {7'h00, tbl_ok}, 8'h00);
    @(posedge clk);
    tbl_exec_ext <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("gate internal", {7'h00, tbl_ok}, 8'h01);
  endtask

  // Encryption encodes reads; the lock bit then hides code bytes.
  task automatic t_crypt_lock();
    pg(SEC_ADDR, 8'hFB);
    chk("sec crypt", sec_bits, 8'hF9);
    rd("crypt", 1'b0, 1'b0, SUP_HIGH, 16'h1234, 8'h50 ^ ENC_KEY ^ 8'h34);
    pg(SEC_ADDR, 8'hFE);
    chk("sec lock", sec_bits, 8'hF8);
    rd("locked", 1'b0, 1'b0, SUP_HIGH, 16'h1234, LOCK_FILL);
  endtask

  // Main sequence.
  initial begin
    err_total    = 0;
    compares     = 0;
    resetn       = 1'b0;
    tbl_exec_ext = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_sec_pre();
    t_erase();
    t_prog();
    t_faults();
    t_table();
    t_crypt_lock();
    final_report();
  end
endmodule // fpma_top_tb_top

`default_nettype wire
